// *** core/ccrc_defs.svh ***
// Purpose: offsets, field positions, reset values and timing counts for clock/reset control
// Assumes: included by bare name from the design files
// Notes:   offsets are register indices on the plain register port
`ifndef CCRC_DEFS_SVH
`define CCRC_DEFS_SVH

`define CCRC_ADDR_W          4
`define CCRC_OFF_PWRCTL      4'h0
`define CCRC_OFF_STATUS      4'h1
`define CCRC_OFF_RATIO       4'h2

// power management control fields
`define CCRC_PM_MULT_LSB     0
`define CCRC_PM_MULT_W       6
`define CCRC_PM_DIV_LSB      6
`define CCRC_PM_DIV_W        4
`define CCRC_PM_PINSEL_BIT   12
`define CCRC_PM_USER_MASK    32'h0000_13FF
`define CCRC_PM_RESET        32'h0000_0000

// start-up multiplier per ratio code
`define CCRC_MULT_RATIO0     6'h03
`define CCRC_MULT_RATIO1     6'h10
`define CCRC_MULT_RATIO2     6'h08
`define CCRC_DIV_RESET       4'h1

// lock wait in input clock cycles
`define CCRC_LOCK_CYCLES     4096
`define CCRC_LOCK_W          13

`endif

// *** core/ccrc_pkg.sv ***
// Purpose: types for clock/reset control
// Assumes: constants come from ccrc_defs.svh
// Notes:   none
package ccrc_pkg;

  typedef enum logic [1:0] {
    CCRC_HOLD = 2'b00,
    CCRC_LOCK = 2'b01,
    CCRC_RUN  = 2'b11
  } ccrc_state_t;

  typedef struct packed {
    logic [3:0] div;
    logic [5:0] mult;
  } ccrc_pll_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } ccrc_bus_t;

endpackage

// *** core/ccrc_sync2.sv ***
// Purpose: two flip-flop synchroniser for pin levels
// Assumes: one clock, synchronous active high reset
// Notes:   first stage is read only by the second stage
module ccrc_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // level in and out
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] stage1_r;
  logic [W-1:0] stage2_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      stage1_r <= '0;
      stage2_r <= '0;
    end else begin
      stage1_r <= din;
      stage2_r <= stage1_r;
    end
  end

  assign dout = stage2_r;

endmodule

// *** core/ccrc_top.sv ***
// Purpose: core clock source/ratio select, pll programming, lock hold-off and shared reset/clock out pin
// Assumes: mclk stands for the input clock; pll clock arrives as a sampled pin level
// Notes:   start ratio is caught from the pins at the release of reset, not from software
`include "ccrc_defs.svh"
module ccrc_top (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // pins
  input  wire logic [1:0]  coreRatioSelect,
  input  wire logic        resetInN,
  input  wire logic        pllClockIn,
  output logic             resetOrClockOut,
  // core side
  output logic             coreResetN,
  output logic             useRefClock,
  output logic [5:0]       pllMult,
  output logic [3:0]       pllDiv,
  output logic             ratioReserved,
  // register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [31:0]      regRdata
);

  logic [1:0]  ratioPins;
  logic        resetInSync;
  logic        pllClkSync;

  ccrc_sync2 #(.W(4)) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .din  ({coreRatioSelect, resetInN, pllClockIn}),
    .dout ({ratioPins, resetInSync, pllClkSync})
  );

  // pin ratio decode, used for both startup load and status view
  function automatic logic [5:0] ratio_mult(input logic [1:0] code);
    case (code)
      2'b00:   ratio_mult = `CCRC_MULT_RATIO0;
      2'b01:   ratio_mult = `CCRC_MULT_RATIO1;
      2'b10:   ratio_mult = `CCRC_MULT_RATIO2;
      default: ratio_mult = 6'h00;
    endcase
  endfunction

  ccrc_pkg::ccrc_state_t state_r;
  ccrc_pkg::ccrc_state_t state_nxt;
  logic [`CCRC_LOCK_W-1:0] lockCnt_r;
  logic [`CCRC_LOCK_W-1:0] lockCnt_nxt;
  logic [31:0]             pwrCtl_r;
  logic [31:0]             pwrCtl_nxt;
  logic [1:0]              ratioCode_r;
  logic                    reserved_r;
  logic                    coreResetN_r;
  logic                    pinOut_r;
  logic                    useRef_r;
  logic [31:0]             rdata_r;
  logic [31:0]             rdata_nxt;

  wire logic inReset   = ~resetInSync;
  wire logic lockDone  = (lockCnt_r == `CCRC_LOCK_W'(`CCRC_LOCK_CYCLES - 1));
  wire logic running   = (state_r == ccrc_pkg::CCRC_RUN);
  wire logic wrPm      = regWr & (regAddr == `CCRC_OFF_PWRCTL) & running;
  wire logic pinIsClk  = pwrCtl_r[`CCRC_PM_PINSEL_BIT];

  // hold while reset pin is low, count lock time after it rises
  always_comb begin
    state_nxt   = state_r;
    lockCnt_nxt = lockCnt_r;
    case (state_r)
      ccrc_pkg::CCRC_HOLD: begin
        lockCnt_nxt = '0;
        if (!inReset) begin
          state_nxt = ccrc_pkg::CCRC_LOCK;
        end
      end
      ccrc_pkg::CCRC_LOCK: begin
        lockCnt_nxt = lockCnt_r + `CCRC_LOCK_W'(1);
        if (lockDone) begin
          state_nxt = ccrc_pkg::CCRC_RUN;
        end
      end
      ccrc_pkg::CCRC_RUN: begin
        lockCnt_nxt = lockCnt_r;
      end
      default: begin
        state_nxt = ccrc_pkg::CCRC_HOLD;
      end
    endcase
    if (inReset) begin
      state_nxt   = ccrc_pkg::CCRC_HOLD;
      lockCnt_nxt = '0;
    end
  end

  // software owns the pll fields only once the core runs; pins seed them on reset release
  ccrc_pkg::ccrc_pll_t startPll;
  assign startPll.mult = ratio_mult(ratioPins);
  assign startPll.div  = `CCRC_DIV_RESET;

  always_comb begin
    pwrCtl_nxt = pwrCtl_r;
    if (state_r == ccrc_pkg::CCRC_HOLD) begin
      pwrCtl_nxt = `CCRC_PM_RESET;
      pwrCtl_nxt[`CCRC_PM_MULT_LSB +: `CCRC_PM_MULT_W] = startPll.mult;
      pwrCtl_nxt[`CCRC_PM_DIV_LSB +: `CCRC_PM_DIV_W]   = startPll.div;
    end else if (wrPm) begin
      pwrCtl_nxt = regWdata & `CCRC_PM_USER_MASK;
    end
  end

  always_comb begin
    case (regAddr)
      `CCRC_OFF_PWRCTL: rdata_nxt = pwrCtl_r;
      `CCRC_OFF_STATUS: rdata_nxt = {28'h0000000, ratioReserved, useRef_r, running, coreResetN_r};
      `CCRC_OFF_RATIO:  rdata_nxt = {24'h000000, ratio_mult(ratioCode_r), ratioCode_r};
      default:          rdata_nxt = 32'h0000_0000;
    endcase
    if (!regRd) begin
      rdata_nxt = 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r      <= ccrc_pkg::CCRC_HOLD;
      lockCnt_r    <= '0;
      pwrCtl_r     <= `CCRC_PM_RESET;
      ratioCode_r  <= 2'h0;
      reserved_r   <= 1'b0;
      coreResetN_r <= 1'b0;
      pinOut_r     <= 1'b0;
      useRef_r     <= 1'b0;
      rdata_r      <= 32'h0000_0000;
    end else begin
      state_r      <= state_nxt;
      lockCnt_r    <= lockCnt_nxt;
      pwrCtl_r     <= pwrCtl_nxt;
      rdata_r      <= rdata_nxt;
      coreResetN_r <= (state_nxt == ccrc_pkg::CCRC_RUN);
      // pins are latched only while held, so they cannot change the ratio later
      if (state_r == ccrc_pkg::CCRC_HOLD) begin
        ratioCode_r <= ratioPins;
        useRef_r    <= (ratioPins == 2'b11);
        reserved_r  <= (ratioPins == 2'b11);
      end
      // reset mode mirrors the core reset; clock mode forwards pll clock
      pinOut_r <= pwrCtl_nxt[`CCRC_PM_PINSEL_BIT] ? pllClkSync : (state_nxt == ccrc_pkg::CCRC_RUN);
    end
  end

  assign coreResetN      = coreResetN_r;
  assign resetOrClockOut = pinOut_r;
  assign useRefClock     = useRef_r;
  assign pllMult         = pwrCtl_r[`CCRC_PM_MULT_LSB +: `CCRC_PM_MULT_W];
  assign pllDiv          = pwrCtl_r[`CCRC_PM_DIV_LSB +: `CCRC_PM_DIV_W];
  assign ratioReserved   = reserved_r;
  assign regRdata        = rdata_r;

  // counts cycles in lock state, for the timing check
  logic [`CCRC_LOCK_W-1:0] lockSeen_r;
  always_ff @(posedge mclk) begin
    if (rst || state_r != ccrc_pkg::CCRC_LOCK) begin
      lockSeen_r <= '0;
    end else begin
      lockSeen_r <= lockSeen_r + `CCRC_LOCK_W'(1);
    end
  end

  a_lock_exit_count: assert property (@(posedge mclk) disable iff (rst)
    (state_r == ccrc_pkg::CCRC_LOCK && state_nxt == ccrc_pkg::CCRC_RUN) |-> lockSeen_r == 13'h0FFF)
    else $error("lock left at wrong count");
  a_core_held_early: assert property (@(posedge mclk) disable iff (rst)
    $rose(coreResetN) |-> $past(lockSeen_r) == 13'h0FFF)
    else $error("core released before lock");
  a_reset_forces_hold: assert property (@(posedge mclk) disable iff (rst)
    inReset |=> state_r == ccrc_pkg::CCRC_HOLD ##1 !coreResetN)
    else $error("reset input did not hold core");
  a_pin_reset_mode: assert property (@(posedge mclk) disable iff (rst)
    (!pinIsClk && running && $past(running)) |-> resetOrClockOut)
    else $error("reset out mode not following core");
  a_pin_default: assert property (@(posedge mclk) disable iff (rst)
    (state_r == ccrc_pkg::CCRC_HOLD) |=> !pinIsClk)
    else $error("pin not reset out after reset");
  a_sw_write_pll: assert property (@(posedge mclk) disable iff (rst)
    (wrPm && !inReset) |=> pllMult == $past(regWdata[5:0]) && pllDiv == $past(regWdata[9:6]))
    else $error("pll write not taken");
  a_pinsel_write: assert property (@(posedge mclk) disable iff (rst)
    (wrPm && !inReset) |=> pinIsClk == $past(regWdata[12]))
    else $error("pin select write not taken");
  a_startup_ratio: assert property (@(posedge mclk) disable iff (rst)
    (state_r == ccrc_pkg::CCRC_HOLD && !inReset && ratioPins == 2'b01) |=> pllMult == 6'h10)
    else $error("startup ratio wrong");
  a_ref_select: assert property (@(posedge mclk) disable iff (rst)
    (state_r == ccrc_pkg::CCRC_HOLD) |=> useRefClock == ($past(ratioPins) == 2'b11))
    else $error("clock source select wrong");

  c_reach_run:   cover property (@(posedge mclk) disable iff (rst) $rose(coreResetN));
  c_clock_mode:  cover property (@(posedge mclk) disable iff (rst) running && pinIsClk);
  c_pll_rewrite: cover property (@(posedge mclk) disable iff (rst) wrPm);

endmodule

// *** dv/ccrc_ext_model.sv ***
// Purpose: external clock source and reset driver beside the clock/reset block
// Assumes: holdReq from the bench asks for the reset pin to be held low
// Notes:   pll clock never stops, not even while reset is held
module ccrc_ext_model (
  // clock and request
  input  wire logic mclk,
  input  wire logic holdReq,
  // pins
  output logic      resetInN,
  output logic      pllClockIn
);
  timeunit 1ns;
  timeprecision 1ps;
  int   phase    = 0;
  logic heldN    = 1'b0;
  logic pllLevel = 1'b0;
  // pll clock runs free with a half period of three input clocks
  always @(posedge mclk) begin
    heldN    <= ~holdReq;
    phase    <= (phase == 5) ? 0 : phase + 1;
    pllLevel <= (phase >= 3);
  end
  assign resetInN   = heldN;
  assign pllClockIn = pllLevel;
endmodule

// *** dv/tb.sv ***
// Purpose: self-checking bench for the clock/reset block
// Assumes: one 50 MHz clock, plain register port
// Notes:   lock wait accepted with a few edges of sync slack
`include "ccrc_defs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int L = `CCRC_LOCK_CYCLES;
  logic mclk, rst, holdReq, regWr, regRd;
  logic [1:0] coreRatioSelect;
  logic [3:0] regAddr;
  logic [31:0] regWdata;
  wire logic resetInN, pllClockIn, resetOrClockOut, coreResetN, useRefClock, ratioReserved;
  wire logic [5:0] pllMult;
  wire logic [3:0] pllDiv;
  wire logic [31:0] regRdata;
  int nMismatch = 0;
  int numChecks = 0;
  int expMult[3] = '{3, 16, 8};
  // expected readback of each control write that is read back, in write order
  int pwrModel[$];

  ccrc_ext_model ext (.mclk(mclk), .holdReq(holdReq), .resetInN(resetInN), .pllClockIn(pllClockIn));
  ccrc_top DUT (.mclk(mclk), .rst(rst), .coreRatioSelect(coreRatioSelect), .resetInN(resetInN),
    .pllClockIn(pllClockIn), .resetOrClockOut(resetOrClockOut), .coreResetN(coreResetN),
    .useRefClock(useRefClock), .pllMult(pllMult), .pllDiv(pllDiv), .ratioReserved(ratioReserved),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata));

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    numChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic regWrite(logic [3:0] a, logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
    #1;
  endtask

  // data stands only in the cycle after the strobe, so sample just past that edge
  task automatic regRead(logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask

  task automatic chkRead(string what, logic [3:0] a, logic [31:0] exp);
    logic [31:0] d;
    regRead(a, d);
    chk(what, exp, d);
  endtask

  task automatic bootWith(logic [1:0] code, output int waited);
    @(posedge mclk);
    holdReq <= 1'b1;
    coreRatioSelect <= code;
    repeat (8) @(posedge mclk);
    regWrite(`CCRC_OFF_PWRCTL, 32'h0000_1005);
    chk("heldCore", 0, coreResetN);
    chk("heldPin", 0, resetOrClockOut);
    @(posedge mclk);
    holdReq <= 1'b0;
    waited = 0;
    while (coreResetN !== 1'b1 && waited < 5000) begin
      @(posedge mclk);
      #1 waited++;
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", numChecks, nMismatch);
    if (nMismatch == 0 && numChecks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // four boots of about 4100 cycles each fit well inside this span
  initial begin
    repeat (40000) @(posedge mclk);
    nMismatch++;
    tally_and_finish();
  end

  initial begin
    int w;
    logic [31:0] v;
    rst = 1'b1;
    holdReq = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 4'h0;
    regWdata = 32'h0;
    coreRatioSelect = 2'h0;
    void'($urandom(10333));
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      bootWith(c[1:0], w);
      chk("lockWait", 1, (w >= L && w <= L + 6));
      chk("pinOut", 1, resetOrClockOut);
      chk("useRef", (c == 3), useRefClock);
      chk("reserved", (c == 3), ratioReserved);
      if (c < 3) chk("startMult", expMult[c], pllMult);
      if (c < 3) chk("startDiv", `CCRC_DIV_RESET, pllDiv);
      $display("boot with code %0d done", c);
    end
    repeat (6) begin
      // pin select kept clear so the pin must stay in reset out mode
      v = $urandom & 32'hFFFF_EFFF;
      pwrModel.push_back(v & `CCRC_PM_USER_MASK);
      regWrite(`CCRC_OFF_PWRCTL, v);
      chk("mult", v[5:0], pllMult);
      chk("div", v[9:6], pllDiv);
      chkRead("pwrCtlRead", `CCRC_OFF_PWRCTL, pwrModel.pop_front());
      chk("pinOut", 1, resetOrClockOut);
    end
    chkRead("unmapped", 4'hF, 32'h0000_0000);
    $display("pll reprogramming done");
    pwrModel.push_back(32'hFFFF_FFFF & `CCRC_PM_USER_MASK);
    regWrite(`CCRC_OFF_PWRCTL, 32'hFFFF_FFFF);
    chkRead("pwrCtlMask", `CCRC_OFF_PWRCTL, pwrModel.pop_front());
    w = 0;
    v[0] = resetOrClockOut;
    repeat (24) begin
      @(posedge mclk);
      #1 if (resetOrClockOut !== v[0]) w++;
      v[0] = resetOrClockOut;
    end
    chk("clockOutToggles", 1, (w >= 6 && w <= 9));
    regWrite(`CCRC_OFF_PWRCTL, 32'h0);
    chk("backToReset", 1, resetOrClockOut);
    @(posedge mclk);
    holdReq <= 1'b1;
    repeat (8) @(posedge mclk);
    #1 chk("dropCore", 0, coreResetN);
    chk("dropPin", 0, resetOrClockOut);
    $display("pin select and reset drop done");
    tally_and_finish();
  end
endmodule
